// [core/sebm_core.sv]
// Serial EEPROM bus master: register side on clk, bit engine on link_clk
`timescale 1ns/1ps
module sebm_core
   import sebm_pkg::*;
#(
   parameter int unsigned LINK_CLK_HZ = 20833333,
   parameter logic [7:0]  DL_BYTES    = 8'd49
)
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       link_clk,
   input  wire logic       pcie_reset_n,
   input  wire logic       global_reset_n,
   input  wire logic [7:0] cfg_addr,
   input  wire logic       cfg_wr,
   input  wire logic [7:0] cfg_wdata,
   output logic      [7:0] cfg_rdata,
   output logic            dl_valid,
   output logic      [7:0] dl_addr,
   output logic      [7:0] dl_data,
   output logic            scl_o,
   output logic            scl_oe_n,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n
);
   // Quarter of an SCL period; rounds down so the bus runs at or just above 60 kHz
   localparam int unsigned QTR_CYC = LINK_CLK_HZ / (SEBM_QUARTERS * SEBM_SCL_HZ);
   localparam int unsigned QW      = $clog2(QTR_CYC + 1);
   localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYC - 1);

   typedef struct packed {
      logic       pr1, pr2, gr1, gr2, sd1, sd2, both_q;
      logic       rx1, rx2, rx3, dn1, dn2, dn3;
      logic       detect, skip, err, busy, dl_active, req_tgl, op_read;
      logic [7:0] count, c_waddr, c_wdata;
      logic [6:0] c_slave, slave;
      logic [7:0] waddr, wdata, rdata, dl_idx;
      logic       dl_valid;
      logic [7:0] dl_addr, dl_data, rdout;
   } sebm_core_t;

   typedef struct packed {
      logic         rl1, rl2;
      logic         rs1, rs2, seen, sd1, sd2;
      sebm_lstate_t st;
      sebm_seg_t    seg;
      logic [1:0]   q;
      logic [QW-1:0] cnt;
      logic [2:0]   bitn;
      logic [7:0]   sh, remain, rx_byte;
      logic         rx_tgl, done_tgl, err, scl_low, sda_low;
   } sebm_link_t;

   sebm_core_t c_q, c_d;
   sebm_link_t l_q, l_d;
   logic       link_rst_b;

   // Byte placed on the wire for each transmit segment
   function automatic logic [7:0] seg_byte(input sebm_seg_t s);
      case (s)
         SEBM_SEG_AW: seg_byte = {c_q.c_slave, SEBM_DIR_WRITE};
         SEBM_SEG_WA: seg_byte = c_q.c_waddr;
         SEBM_SEG_WD: seg_byte = c_q.c_wdata;
         SEBM_SEG_AR: seg_byte = {c_q.c_slave, SEBM_DIR_READ};
         default:     seg_byte = c_q.c_wdata;
      endcase
   endfunction

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      case (a)
         SEBM_REG_DATA:  reg_read = c_q.rdata;
         SEBM_REG_WADDR: reg_read = c_q.waddr;
         SEBM_REG_SLAVE: reg_read = {1'b0, c_q.slave};
         SEBM_REG_CTRL:
         begin
            reg_read = 8'h00;
            reg_read[SEBM_SKIP_BIT] = c_q.skip;
            reg_read[SEBM_BUSY_BIT] = c_q.busy;
            reg_read[SEBM_DET_BIT]  = c_q.detect;
            reg_read[SEBM_ERR_BIT]  = c_q.err;
         end
         default:        reg_read = 8'h00;
      endcase
   endfunction

   // Core domain
   always_comb
   begin
      logic both;
      logic start_sw;
      both = 1'b0;
      start_sw = 1'b0;
      c_d = c_q;
      c_d.pr1 = pcie_reset_n;
      c_d.pr2 = c_q.pr1;
      c_d.gr1 = global_reset_n;
      c_d.gr2 = c_q.gr1;
      c_d.sd1 = sda_i;
      c_d.sd2 = c_q.sd1;
      c_d.rx1 = l_q.rx_tgl;
      c_d.rx2 = c_q.rx1;
      c_d.rx3 = c_q.rx2;
      c_d.dn1 = l_q.done_tgl;
      c_d.dn2 = c_q.dn1;
      c_d.dn3 = c_q.dn2;
      c_d.dl_valid = 1'b0;
      c_d.rdout = reg_read(cfg_addr);
      both = c_q.pr2 & c_q.gr2;
      c_d.both_q = both;
      if (cfg_wr)
      begin
         case (cfg_addr)
            SEBM_REG_DATA:  c_d.wdata = cfg_wdata;
            SEBM_REG_WADDR: c_d.waddr = cfg_wdata;
            SEBM_REG_SLAVE: c_d.slave = cfg_wdata[6:0];
            SEBM_REG_CTRL:
            begin
               c_d.skip = cfg_wdata[SEBM_SKIP_BIT];
               if (!cfg_wdata[SEBM_DET_BIT])
                  c_d.detect = 1'b0;
               if (cfg_wdata[SEBM_ERR_BIT])
                  c_d.err = 1'b0;
               start_sw = cfg_wdata[SEBM_RD_BIT] | cfg_wdata[SEBM_WR_BIT];
            end
            default: c_d.wdata = c_q.wdata;
         endcase
      end
      // Slave, word address, data and direction are latched against later register writes; skip is read live by the link side
      if (start_sw && !c_q.busy && c_q.detect)
      begin
         c_d.op_read = cfg_wdata[SEBM_RD_BIT];
         c_d.count   = SEBM_ONE_BYTE;
         c_d.c_waddr = c_q.waddr;
         c_d.c_wdata = c_q.wdata;
         c_d.c_slave = c_q.slave;
         c_d.busy    = 1'b1;
         c_d.req_tgl = ~c_q.req_tgl;
      end
      if (both && !c_q.both_q)
      begin
         c_d.detect = c_q.sd2;
         if (c_q.sd2 && !c_q.busy)
         begin
            c_d.op_read   = 1'b1;
            c_d.count     = DL_BYTES;
            c_d.c_waddr   = SEBM_DL_WADDR;
            c_d.c_slave   = c_q.slave;
            c_d.busy      = 1'b1;
            c_d.dl_active = 1'b1;
            c_d.dl_idx    = SEBM_DL_WADDR;
            c_d.req_tgl   = ~c_q.req_tgl;
         end
      end
      if (c_q.rx2 != c_q.rx3)
      begin
         if (c_q.dl_active)
         begin
            c_d.dl_valid = 1'b1;
            c_d.dl_addr  = c_q.dl_idx;
            c_d.dl_data  = l_q.rx_byte;
            c_d.dl_idx   = c_q.dl_idx + 8'h01;
         end
         else
            c_d.rdata = l_q.rx_byte;
      end
      if (c_q.dn2 != c_q.dn3)
      begin
         c_d.busy = 1'b0;
         c_d.dl_active = 1'b0;
         // Set after the software clear so a coincident error is kept
         if (l_q.err)
            c_d.err = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         c_q <= '0;
         c_q.slave <= SEBM_SLAVE_RST;
         c_q.c_slave <= SEBM_SLAVE_RST;
      end
      else
         c_q <= c_d;
   end

   // Link domain; reset is asserted at once and released in step with link_clk
   always_comb
   begin
      logic tick;
      logic last;
      tick = 1'b0;
      last = 1'b0;
      l_d = l_q;
      l_d.rs1 = c_q.req_tgl;
      l_d.rs2 = l_q.rs1;
      l_d.sd1 = sda_i;
      l_d.sd2 = l_q.sd1;
      if (l_q.st != SEBM_L_IDLE)
      begin
         tick = (l_q.cnt == QTR_LAST);
         l_d.cnt = tick ? '0 : l_q.cnt + QW'(1);
         if (tick)
            l_d.q = l_q.q + 2'h1;
      end
      last = tick && (l_q.q == SEBM_Q_LAST);
      case (l_q.st)
         SEBM_L_IDLE:
            if (l_q.rs2 != l_q.seen)
            begin
               l_d.seen   = l_q.rs2;
               l_d.st     = SEBM_L_START;
               l_d.q      = SEBM_Q_FIRST;
               l_d.cnt    = '0;
               l_d.err    = 1'b0;
               l_d.remain = c_q.count;
               l_d.seg    = (c_q.op_read && c_q.skip) ? SEBM_SEG_AR : SEBM_SEG_AW;
            end
         SEBM_L_START:
            if (last)
            begin
               l_d.st   = SEBM_L_TX;
               l_d.sh   = seg_byte(l_q.seg);
               l_d.bitn = '0;
            end
         SEBM_L_TX:
            if (last)
            begin
               l_d.sh   = {l_q.sh[6:0], 1'b0};
               l_d.bitn = l_q.bitn + 3'h1;
               if (l_q.bitn == SEBM_BIT_LAST)
                  l_d.st = SEBM_L_TXACK;
            end
         SEBM_L_TXACK:
            if (last)
            begin
               l_d.st = SEBM_L_TX;
               l_d.bitn = '0;
               if (l_q.sd2)
               begin
                  l_d.err = 1'b1;
                  l_d.st  = SEBM_L_STOP;
               end
               else
                  case (l_q.seg)
                     SEBM_SEG_AW:
                     begin
                        l_d.seg = (!c_q.op_read && c_q.skip) ? SEBM_SEG_WD : SEBM_SEG_WA;
                        l_d.sh  = seg_byte(l_d.seg);
                     end
                     SEBM_SEG_WA:
                        if (c_q.op_read)
                        begin
                           l_d.seg = SEBM_SEG_AR;
                           l_d.st  = SEBM_L_START;
                        end
                        else
                        begin
                           l_d.seg = SEBM_SEG_WD;
                           l_d.sh  = seg_byte(SEBM_SEG_WD);
                        end
                     SEBM_SEG_WD: l_d.st = SEBM_L_STOP;
                     default:     l_d.st = SEBM_L_RX;
                  endcase
            end
         SEBM_L_RX:
            if (last)
            begin
               l_d.sh   = {l_q.sh[6:0], l_q.sd2};
               l_d.bitn = l_q.bitn + 3'h1;
               if (l_q.bitn == SEBM_BIT_LAST)
               begin
                  l_d.st      = SEBM_L_RXACK;
                  l_d.rx_byte = {l_q.sh[6:0], l_q.sd2};
                  l_d.rx_tgl  = ~l_q.rx_tgl;
               end
            end
         SEBM_L_RXACK:
            if (last)
            begin
               l_d.remain = l_q.remain - 8'h01;
               l_d.bitn   = '0;
               l_d.st     = (l_q.remain > SEBM_ONE_BYTE) ? SEBM_L_RX : SEBM_L_STOP;
            end
         SEBM_L_STOP:
            if (last)
            begin
               l_d.st       = SEBM_L_IDLE;
               l_d.done_tgl = ~l_q.done_tgl;
            end
         default: l_d.st = SEBM_L_IDLE;
      endcase
      // Pin levels per quarter; SDA only moves while SCL is low except at start and stop
      l_d.scl_low = 1'b0;
      l_d.sda_low = 1'b0;
      case (l_q.st)
         SEBM_L_START:
         begin
            l_d.scl_low = (l_q.q == SEBM_Q_FIRST) || (l_q.q == SEBM_Q_LAST);
            l_d.sda_low = (l_q.q >= SEBM_Q_SCL_HI);
         end
         SEBM_L_TX:
         begin
            l_d.scl_low = (l_q.q < SEBM_Q_SCL_HI);
            l_d.sda_low = ~l_q.sh[7];
         end
         SEBM_L_TXACK, SEBM_L_RX: l_d.scl_low = (l_q.q < SEBM_Q_SCL_HI);
         SEBM_L_RXACK:
         begin
            l_d.scl_low = (l_q.q < SEBM_Q_SCL_HI);
            l_d.sda_low = (l_q.remain > SEBM_ONE_BYTE);
         end
         SEBM_L_STOP:
         begin
            l_d.scl_low = (l_q.q < SEBM_Q_SCL_HI);
            l_d.sda_low = (l_q.q != SEBM_Q_LAST);
         end
         default:
         begin
            l_d.scl_low = 1'b0;
            l_d.sda_low = 1'b0;
         end
      endcase
      // SDA waits a quarter after SCL falls so both pins never move on one edge
      if ((l_q.st != SEBM_L_IDLE) && (l_q.q == SEBM_Q_FIRST))
         l_d.sda_low = l_q.sda_low;
      l_d.rl1 = 1'b1;
      l_d.rl2 = l_q.rl1;
   end

   assign link_rst_b = l_q.rl2;

   always_ff @(posedge link_clk or negedge rst_b)
   begin
      if (!rst_b)
         l_q <= '0;
      else if (!link_rst_b)
      begin
         l_q     <= '0;
         l_q.rl1 <= 1'b1;
         l_q.rl2 <= l_q.rl1;
      end
      else
         l_q <= l_d;
   end

   assign cfg_rdata = c_q.rdout;
   assign dl_valid  = c_q.dl_valid;
   assign dl_addr   = c_q.dl_addr;
   assign dl_data   = c_q.dl_data;
   // Open drain: lines are only ever pulled low, high comes from the pull-ups
   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign scl_oe_n  = ~l_q.scl_low;
   assign sda_oe_n  = ~l_q.sda_low;
endmodule : sebm_core

// [pkg/sebm_pkg.sv]
// Constants, types and states of the serial EEPROM bus master
// Notes on behaviour
// - At later release of both resets, sample SDA; pulled high sets eeprom_detect bit.
// - Writing 0 to eeprom_detect disables the interface; SDA low at reset keeps it off.
// - SCL is output only, SDA is bidirectional; both open-drain with external pull-ups.
// - SCL toggles near 60 kHz during transfers and is released, static, when idle.
// - Only the master starts transfers, with SDA falling while SCL is high.
// - A transfer ends with a stop: SDA rising while SCL is high.
// - SDA stays stable while SCL is high except for start and stop.
// - Bytes are eight bits; the receiver acknowledges each by holding SDA low.
// - Software starts single-byte writes and reads; reset release starts a multibyte read.
// - Write: start, address+0, ack, word address, ack, data MSB first, ack, stop.
// - A missing acknowledge sets nack_error_flag in the control/status register.
// - Read: start, address+0, word address, restart, address+1, byte, no-ack, stop.
// - Multibyte read: master acks every byte but the last, then no-ack and stop.
// - With skip_word_addr_select set, the word address and its ack are left out.
// - A detected EEPROM at reset release starts the download automatically.
package sebm_pkg;
   localparam logic [7:0] SEBM_REG_DATA   = 8'hb0;
   localparam logic [7:0] SEBM_REG_WADDR  = 8'hb1;
   localparam logic [7:0] SEBM_REG_SLAVE  = 8'hb2;
   localparam logic [7:0] SEBM_REG_CTRL   = 8'hb3;
   localparam int unsigned SEBM_SKIP_BIT  = 7;
   localparam int unsigned SEBM_RD_BIT    = 6;
   localparam int unsigned SEBM_WR_BIT    = 5;
   localparam int unsigned SEBM_BUSY_BIT  = 4;
   localparam int unsigned SEBM_DET_BIT   = 3;
   localparam int unsigned SEBM_ERR_BIT   = 1;
   localparam logic [6:0] SEBM_SLAVE_RST  = 7'h50;
   localparam logic       SEBM_DIR_WRITE  = 1'b0;
   localparam logic       SEBM_DIR_READ   = 1'b1;
   localparam logic [7:0] SEBM_DL_WADDR   = 8'h00;
   localparam int unsigned SEBM_SCL_HZ    = 60000;
   localparam int unsigned SEBM_QUARTERS  = 4;
   localparam logic [1:0] SEBM_Q_FIRST    = 2'h0;
   localparam logic [1:0] SEBM_Q_SCL_HI   = 2'h2;
   localparam logic [1:0] SEBM_Q_LAST     = 2'h3;
   localparam logic [2:0] SEBM_BIT_LAST   = 3'h7;
   localparam logic [7:0] SEBM_ONE_BYTE   = 8'h01;

   typedef enum logic [2:0] {
      SEBM_SEG_AW = 3'h0,
      SEBM_SEG_WA = 3'h1,
      SEBM_SEG_WD = 3'h2,
      SEBM_SEG_AR = 3'h3
   } sebm_seg_t;

   typedef enum logic [2:0] {
      SEBM_L_IDLE  = 3'b000,
      SEBM_L_START = 3'b001,
      SEBM_L_TX    = 3'b011,
      SEBM_L_TXACK = 3'b010,
      SEBM_L_RX    = 3'b110,
      SEBM_L_RXACK = 3'b111,
      SEBM_L_STOP  = 3'b101
   } sebm_lstate_t;
endpackage : sebm_pkg

// [verification/sebm_core_monitor.sv]
// Pin, register-read and download-strobe assertion checker for the serial EEPROM bus master
`timescale 1ns/1ps
module sebm_core_monitor
   import sebm_pkg::*;
#(
   parameter int unsigned LINK_CLK_HZ = 20833333
)
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       link_clk,
   input wire logic       pcie_reset_n,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_rdata,
   input wire logic       dl_valid,
   input wire logic [7:0] dl_addr,
   input wire logic       scl_o,
   input wire logic       scl_oe_n,
   input wire logic       sda_o,
   input wire logic       sda_oe_n
);
   localparam int QTR = LINK_CLK_HZ / 240000;
   localparam int LOW_MAX = 3 * QTR;
   logic [15:0] low_q;
   logic [7:0]  dlc_q;
   // Longest SCL low stretch is start q3 plus the next bit's two low quarters
   always_ff @(posedge link_clk or negedge rst_b)
      if (!rst_b)
         low_q <= 16'h0;
      else
         low_q <= scl_oe_n ? 16'h0 : low_q + 16'h1;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         dlc_q <= 8'h0;
      else if (!pcie_reset_n)
         dlc_q <= 8'h0;
      else if (dl_valid)
         dlc_q <= dlc_q + 8'h1;
   sequence s_start;
      $fell(sda_oe_n) && scl_oe_n;
   endsequence
   sequence s_stop;
      $rose(sda_oe_n) && scl_oe_n;
   endsequence
   a_start_scl_held: assert property (@(posedge link_clk) disable iff (!rst_b)
      s_start |-> $past(scl_oe_n, 2)) else $error("start while SCL not high");
   a_start_then_low: assert property (@(posedge link_clk) disable iff (!rst_b)
      s_start |-> !sda_oe_n throughout (##[1:QTR] !scl_oe_n)) else $error("start not followed by SCL low");
   a_stop_then_idle: assert property (@(posedge link_clk) disable iff (!rst_b)
      s_stop |=> (scl_oe_n && sda_oe_n) [*2]) else $error("bus not idle after stop");
   a_sda_still_rise: assert property (@(posedge link_clk) disable iff (!rst_b)
      $rose(scl_oe_n) |-> $stable(sda_oe_n)) else $error("SDA moved as SCL rose");
   a_sda_still_fall: assert property (@(posedge link_clk) disable iff (!rst_b)
      $fell(scl_oe_n) |-> $stable(sda_oe_n)) else $error("SDA moved as SCL fell");
   a_scl_low_bound: assert property (@(posedge link_clk) disable iff (!rst_b)
      low_q <= LOW_MAX) else $error("SCL low too long");
   a_open_drain: assert property (@(posedge link_clk) disable iff (!rst_b)
      !scl_o && !sda_o) else $error("line driven high");
   a_ctrl_zero_bits: assert property (@(posedge clk) disable iff (!rst_b)
      $past(cfg_addr) == SEBM_REG_CTRL |-> cfg_rdata[6:5] == 2'h0 && !cfg_rdata[2] && !cfg_rdata[0])
      else $error("control reserved bits set");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
      ($past(cfg_addr) > 8'hb3 || $past(cfg_addr) < 8'hb0) |-> cfg_rdata == 8'h00) else $error("unmapped not zero");
   a_dl_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      dl_valid |=> !dl_valid) else $error("download strobe too long");
   a_dl_order: assert property (@(posedge clk) disable iff (!rst_b)
      dl_valid |-> dl_addr == dlc_q) else $error("download address out of order");
endmodule // sebm_core_monitor

// [verification/sebm_eeprom_model.sv]
// Behavioural two-wire EEPROM slave
`timescale 1ns/1ps
module sebm_eeprom_model
#(
   parameter logic [6:0] DEV_ADDR = 7'h50
)
(
   input wire logic scl,
   input wire logic sda,
   output logic     sda_low
);
   logic [7:0] mem [256];
   logic [7:0] sh, ob, wa;
   int         cnt, ph;
   logic       act, rd, ack, more, go;
   initial
   begin
      sda_low = 1'b0;
      act = 1'b0;
      wa = 8'h00;
   end
   always @(negedge sda)
      if (scl)
      begin
         act = 1'b1;
         rd = 1'b0;
         cnt = 0;
         ph = 0;
      end
   always @(posedge sda)
      if (scl)
         act = 1'b0;
   always @(posedge scl)
      if (act)
      begin
         if (!rd && cnt < 8)
            sh = {sh[6:0], sda};
         if (rd && cnt == 8)
            more = !sda;
         cnt = cnt + 1;
      end
   // Changes its SDA drive only on SCL falling edges, so SDA never moves in a high phase
   always @(negedge scl)
      if (!act)
         sda_low = 1'b0;
      else if (cnt == 8 && !rd)
      begin
         ack = (ph != 0) || (sh[7:1] == DEV_ADDR);
         go = (ph == 0) && sh[0];
         if (ph == 1)
            wa = sh;
         if (ph == 2)
            mem[wa] = sh;
         if (ph == 2)
            wa = wa + 8'h1;
         ph = (ph == 0) ? 1 : 2;
         sda_low = ack;
      end
      else if (cnt == 9)
      begin
         cnt = 0;
         if (go)
            rd = 1'b1;
         if (go)
            more = 1'b1;
         go = 1'b0;
         if (!ack || (rd && !more))
            act = 1'b0;
         if (act && rd)
            ob = mem[wa];
         if (act && rd)
            wa = wa + 8'h1;
         sda_low = act && rd && !ob[7];
      end
      else if (rd)
         sda_low = (cnt < 8) && !ob[7 - cnt];
endmodule // sebm_eeprom_model

// [verification/sebm_core_tb_top.sv]
// Self-checking bench for the serial EEPROM bus master
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module sebm_core_tb_top;
   import sebm_pkg::*;
   typedef struct packed {logic r; logic s; logic [7:0] wa; logic [7:0] d;} sebm_row_t;
   logic       clk = 0, link_clk = 0, rst_b = 0, pcie_reset_n = 0, global_reset_n = 0;
   logic [7:0] cfg_addr = 0, cfg_wdata = 0, cfg_rdata, dl_addr, dl_data, v, dl_got [3];
   logic       cfg_wr = 0, dl_valid, scl_o, scl_oe_n, sda_o, sda_oe_n, slave_low, pull_dn = 0, seen;
   wire        scl = scl_oe_n ? 1'b1 : scl_o;
   wire        sda_i = (sda_oe_n ? 1'b1 : sda_o) & !slave_low & !pull_dn;
   int         failures = 0, samples_checked = 0, dl_n = 0;
   // A skip-mode write only sets the slave's address pointer, so the skip-mode read after it returns that word
   sebm_row_t  rows [6] = '{'{0, 0, 8'h10, 8'h5a}, '{1, 0, 8'h10, 8'h5a}, '{0, 0, 8'hff, 8'hc3},
                            '{1, 0, 8'hff, 8'hc3}, '{0, 1, 8'h00, 8'h3c}, '{1, 1, 8'h00, 8'h99}};
   always #5 clk = ~clk;
   always #24 link_clk = ~link_clk;
   sebm_core #(.LINK_CLK_HZ(480000), .DL_BYTES(8'd3)) dut (.clk, .rst_b, .link_clk, .pcie_reset_n,
      .global_reset_n, .cfg_addr, .cfg_wr, .cfg_wdata, .cfg_rdata, .dl_valid, .dl_addr, .dl_data,
      .scl_o, .scl_oe_n, .sda_i, .sda_o, .sda_oe_n);
   sebm_eeprom_model eep (.scl(scl), .sda(sda_i), .sda_low(slave_low));
   always @(posedge clk)
      if (dl_valid)
      begin
         dl_got[dl_addr[1:0]] <= dl_data;
         dl_n <= dl_n + 1;
      end
   task automatic give_verdict();
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      cfg_addr = a;
      @(negedge clk);
      d = cfg_rdata;
   endtask
   // Polls busy; a hung transfer ends the run rather than stalling it
   task automatic wait_idle();
      logic [7:0] s;
      int n;
      n = 0;
      do
      begin
         rd(SEBM_REG_CTRL, s);
         n++;
      end
      while (s[SEBM_BUSY_BIT] !== 1'b0 && n < 30000);
      if (n >= 30000)
      begin
         failures++;
         give_verdict();
      end
   endtask
   initial
   begin
      for (int k = 0; k < 256; k++)
         eep.mem[k] = k[7:0] ^ 8'ha5;
      repeat (6) @(posedge link_clk);
      @(negedge clk);
      rst_b = 1'b1;
      rd(SEBM_REG_CTRL, v);
      `CHK(v, 8'h00)
      rd(SEBM_REG_SLAVE, v);
      `CHK(v, 8'h50)
      rd(8'hc0, v);
      `CHK(v, 8'h00)
      @(negedge clk) global_reset_n = 1'b1;
      repeat (5) @(negedge clk);
      pcie_reset_n = 1'b1;
      repeat (10) @(negedge clk);
      wait_idle();
      rd(SEBM_REG_CTRL, v);
      `CHK(v, 8'h08)
      `CHK(dl_n, 3)
      for (int k = 0; k < 3; k++)
         `CHK(dl_got[k], k[7:0] ^ 8'ha5)
      foreach (rows[i])
      begin
         wr(SEBM_REG_WADDR, rows[i].wa);
         if (!rows[i].r)
            wr(SEBM_REG_DATA, rows[i].d);
         wr(SEBM_REG_CTRL, {rows[i].s, rows[i].r, !rows[i].r, 5'h08});
         wait_idle();
         rd(SEBM_REG_CTRL, v);
         `CHK(v, {rows[i].s, 7'h08})
         rd(SEBM_REG_DATA, v);
         if (rows[i].r)
            `CHK(v, rows[i].d)
      end
      wr(SEBM_REG_SLAVE, 8'h51);
      wr(SEBM_REG_CTRL, 8'h28);
      wait_idle();
      rd(SEBM_REG_CTRL, v);
      `CHK(v, 8'h0a)
      wr(SEBM_REG_CTRL, 8'h0a);
      rd(SEBM_REG_CTRL, v);
      `CHK(v, 8'h08)
      wr(SEBM_REG_SLAVE, 8'h50);
      wr(SEBM_REG_CTRL, 8'h00);
      wr(SEBM_REG_CTRL, 8'h40);
      seen = 1'b0;
      repeat (300) @(negedge clk) seen |= !scl;
      `CHK(seen, 1'b0)
      rd(SEBM_REG_CTRL, v);
      `CHK(v, 8'h00)
      pull_dn = 1'b1;
      pcie_reset_n = 1'b0;
      global_reset_n = 1'b0;
      repeat (5) @(negedge clk);
      pcie_reset_n = 1'b1;
      global_reset_n = 1'b1;
      repeat (20) @(negedge clk);
      pull_dn = 1'b0;
      rd(SEBM_REG_CTRL, v);
      `CHK(v, 8'h00)
      `CHK(dl_n, 3)
      give_verdict();
   end
endmodule // sebm_core_tb_top
bind sebm_core sebm_core_monitor #(.LINK_CLK_HZ(LINK_CLK_HZ)) u_mon (.clk, .rst_b, .link_clk, .pcie_reset_n,
   .cfg_addr, .cfg_rdata, .dl_valid, .dl_addr, .scl_o, .scl_oe_n, .sda_o, .sda_oe_n);
